// [sgd_cfg.svh]
`ifndef SGD_CFG_SVH
`define SGD_CFG_SVH
`define SGD_WIN_DIV       4
`define SGD_VIS_WINDOWS   40
`define SGD_LINE_WINDOWS  56
`define SGD_FRAME_LINES   312
`define SGD_VIS_LINES_A   250
`define SGD_VIS_LINES_B   210
`define SGD_WIN_TV_LINES  10
`define SGD_WIN_DOTS      8
`define SGD_CODE_CHAR     8:0
`define SGD_CODE_ATTR     15:9
`define SGD_CODE_TYPE     15:12
`define SGD_ATTR_RGB      2:0
`define SGD_ATTR_BOX      3
`define SGD_TYPE_EXT      3
`define SGD_ADR_SECOND    0
`define SGD_ADR_CMD       1
`define SGD_BUSY_BIT      7
`define SGD_OP            6:4
`define SGD_OP_CURSOR     3'h0
`define SGD_OP_MODE       3'h1
`define SGD_OP_XFER       3'h2
`define SGD_XMODE         3:2
`define SGD_HI            1:0
`define SGD_MODE_ON       0
`define SGD_MODE_ROLL     1
`define SGD_MODE_SHORT    2
`define SGD_MODE_SIZE     4:3
`define SGD_SIZE_2        2'h1
`define SGD_SIZE_4        2'h2
`define SGD_ADR_EXT       4
`define SGD_MODE_RESET    8'h01
`endif

// [sgd_pkg.sv]
package sgd_pkg;
  typedef logic [1:0] sgd_dots_t;
  typedef enum logic [1:0] {SGD_XF_PM_WR, SGD_XF_PM_RD, SGD_XF_CG_WR, SGD_XF_CG_RD} sgd_xfer_e;
  typedef enum logic {SGD_A_IDLE, SGD_A_XFER} sgd_acc_e;
endpackage

// [sgd_mbox_if.sv]
`timescale 1ns/1ps
interface sgd_mbox_if;
  logic [7:0] first;
  logic [7:0] second;
  logic       cmd_pend;
  logic       data_pend;
  logic       take;
  logic       load;
  logic [7:0] load_first;
  logic [7:0] load_second;
  logic       rd_mode;
  modport box (output first, second, cmd_pend, data_pend, input take, load, load_first, load_second, rd_mode);
  modport ctl (input first, second, cmd_pend, data_pend, output take, load, load_first, load_second, rd_mode);
endinterface

// [sgd_timing.sv]
`timescale 1ns/1ps
`include "sgd_cfg.svh"
module sgd_timing #(
  parameter int LINE_WIN    = `SGD_LINE_WINDOWS,
  parameter int FRAME_LINES = `SGD_FRAME_LINES
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       short_frame,
  output logic [1:0]      phase,
  output logic [5:0]      col,
  output logic [8:0]      line,
  output logic [3:0]      slice,
  output logic            disp_win,
  output logic            line_end,
  output logic            frame_start
);
  import sgd_pkg::*;
  logic       win_end;
  logic [8:0] vis_lines;

  assign win_end     = phase == 2'(`SGD_WIN_DIV - 1);
  assign line_end    = win_end && col == 6'(LINE_WIN - 1);
  assign frame_start = line_end && line == 9'(FRAME_LINES - 1);
  assign vis_lines   = short_frame ? 9'(`SGD_VIS_LINES_B) : 9'(`SGD_VIS_LINES_A);
  assign disp_win    = col < 6'(`SGD_VIS_WINDOWS) && line < vis_lines;

  always_ff @(posedge ref_clk) begin
    if (rst) phase <= 2'h0;
    else if (win_end) phase <= 2'h0;
    else phase <= phase + 2'h1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst || line_end) col <= 6'h0;
    else if (win_end) col <= col + 6'h1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst || frame_start) begin
      line  <= 9'h0;
      slice <= 4'h0;
    end else if (line_end) begin
      line  <= line + 9'h1;
      slice <= (slice == 4'(`SGD_WIN_TV_LINES - 1)) ? 4'h0 : slice + 4'h1;
    end
  end

  AST_WIN_DIV: assert property (@(posedge ref_clk) disable iff (rst)
    phase == 2'h0 |-> ##1 phase == 2'h1 ##1 phase == 2'h2 ##1 phase == 2'h3 ##1 phase == 2'h0)
    else $error("window is not four clocks");
  AST_GRANT: assert property (@(posedge ref_clk) disable iff (rst)
    disp_win |-> col < 6'(`SGD_VIS_WINDOWS) && line < 9'(`SGD_VIS_LINES_A))
    else $error("display grant outside visible area");
  AST_SLICE_RANGE: assert property (@(posedge ref_clk) disable iff (rst)
    slice <= 4'(`SGD_WIN_TV_LINES - 1))
    else $error("slice number out of range");
  AST_GRANT_SHORT: assert property (@(posedge ref_clk) disable iff (rst)
    short_frame && disp_win |-> line < 9'(`SGD_VIS_LINES_B))
    else $error("display grant outside visible area");
endmodule // sgd_timing

// [sgd_mailbox.sv]
`timescale 1ns/1ps
`include "sgd_cfg.svh"
module sgd_mailbox (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [1:0] host_addr,
  input  wire logic [7:0] host_wdata,
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  output logic [7:0]      host_rdata,
  sgd_mbox_if.box         mb
);
  import sgd_pkg::*;
  logic armed;
  logic sel_second;
  logic sel_cmd;
  logic set_cmd;
  logic set_data;

  assign sel_second = host_addr[`SGD_ADR_SECOND];
  assign sel_cmd    = host_addr[`SGD_ADR_CMD];
  assign set_cmd    = host_wr && sel_second && sel_cmd && armed;
  assign set_data   = !sel_cmd && sel_second && (mb.rd_mode ? host_rd : host_wr);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mb.first  <= 8'h00;
      mb.second <= 8'h00;
    end else if (mb.load) begin
      mb.first  <= mb.load_first;
      mb.second <= mb.load_second;
    end else if (host_wr && !sel_second) mb.first <= host_wdata;
    else if (host_wr) mb.second <= host_wdata;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) armed <= 1'b0;
    else if (host_wr) armed <= !sel_second && sel_cmd;
  end

  // set wins over the device's clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mb.cmd_pend  <= 1'b0;
      mb.data_pend <= 1'b0;
    end else begin
      if (set_cmd) mb.cmd_pend <= 1'b1;
      else if (mb.take) mb.cmd_pend <= 1'b0;
      if (set_data) mb.data_pend <= 1'b1;
      else if (mb.take) mb.data_pend <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || !host_rd) host_rdata <= 8'h00;
    else if (sel_cmd && !sel_second)
      host_rdata <= {mb.cmd_pend | mb.data_pend, mb.first[`SGD_BUSY_BIT-1:0]};
    else host_rdata <= sel_second ? mb.second : mb.first;
  end

  AST_BUSY_SET: assert property (@(posedge ref_clk) disable iff (rst)
    set_cmd ##1 host_rd && host_addr == 2'h2 |=> host_rdata[7])
    else $error("busy not seen after command pair");
endmodule // sgd_mailbox

// [sgd_bus_sequencer.sv]
// How it works
// - window rate is clock divided by four; line and frame divide further
// - display owns bus 40 windows per line, 250 or 210 lines
// - access automaton owns bus at all other times
// - a window is ten tv lines by eight dots
// - a character spans one, two or four windows
// - two read cycles in every displayable window
// - first read fetches window code; latch attribute and character type
// - nine-bit character code goes into the character code registers
// - window address increments after the code fetch of a character's last window
// - second read drives slice number 0..9 and reads eight dots
// - after slice read, red, green, blue and boxing are delivered
// - first then second mailbox write with command select makes command pending
// - access automaton reads pending command once it owns the bus
// - commands: cursor, display mode, or transfer mode
// - data words move through the mailbox per current transfer mode
// - busy shows in msb of first mailbox register under command select
// - all traffic uses one sixteen-bit bus mastered by this block
// - page memory and glyph strobes never active together
// - address carries slice on low four bits, external select on fifth
// - read/write line low for write, high for read
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "sgd_cfg.svh"
module sgd_bus_sequencer #(
  parameter int LINE_WIN    = `SGD_LINE_WINDOWS,
  parameter int FRAME_LINES = `SGD_FRAME_LINES
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [1:0]  host_addr,
  input  wire logic [7:0]  host_wdata,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  output logic [7:0]       host_rdata,
  output logic [9:0]       bus_addr,
  input  wire logic [15:0] bus_din,
  output logic [15:0]      bus_dout,
  output logic             bus_dout_oe_n,
  output logic             page_mem_strobe_n,
  output logic             glyph_gen_strobe_n,
  output logic             internal_rw,
  output logic [8:0]       char_code_regs,
  output sgd_pkg::sgd_dots_t red,
  output sgd_pkg::sgd_dots_t green,
  output sgd_pkg::sgd_dots_t blue,
  output logic             boxing
);
  import sgd_pkg::*;

  sgd_mbox_if mb ();

  logic [1:0]  phase;
  logic [5:0]  col;
  logic [8:0]  line;
  logic [3:0]  slice;
  logic        disp_win;
  logic        line_end;
  logic        frame_start;
  logic [7:0]  mode;
  logic [9:0]  cursor;
  logic [9:0]  win_addr;
  logic [9:0]  row_base;
  logic [9:0]  roll_base;
  logic [9:0]  fetch_addr;
  logic [6:0]  attr;
  logic [3:0]  ctype;
  logic [1:0]  sub;
  logic [1:0]  sub_last;
  logic [7:0]  shifter;
  logic [2:0]  colour;
  logic        box_q;
  logic        vid_on;
  logic        code_cap;
  logic        slice_cap;
  sgd_acc_e    acc_state;
  sgd_xfer_e   xmode;
  logic [9:0]  xfer_addr;
  logic        xf_write;
  logic        xf_glyph;
  logic        cmd_take;
  logic        xf_done;
  logic [2:0]  opcode;
  logic [9:0]  cmd_val;

  sgd_timing #(
    .LINE_WIN    (LINE_WIN),
    .FRAME_LINES (FRAME_LINES)
  ) u_timing (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .short_frame (mode[`SGD_MODE_SHORT]),
    .phase       (phase),
    .col         (col),
    .line        (line),
    .slice       (slice),
    .disp_win    (disp_win),
    .line_end    (line_end),
    .frame_start (frame_start)
  );

  sgd_mailbox u_mailbox (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .host_addr  (host_addr),
    .host_wdata (host_wdata),
    .host_wr    (host_wr),
    .host_rd    (host_rd),
    .host_rdata (host_rdata),
    .mb         (mb.box)
  );

  // widened dots for characters spanning two or four windows
  function automatic logic [7:0] widen(input logic [7:0] s, input logic [1:0] sz, input logic [1:0] k);
    logic [3:0] nib;
    logic [1:0] pr;
    nib = k[0] ? s[3:0] : s[7:4];
    pr  = 2'(s >> (3'h6 - {k, 1'b0}));
    if (sz == `SGD_SIZE_2) widen = {{2{nib[3]}}, {2{nib[2]}}, {2{nib[1]}}, {2{nib[0]}}};
    else if (sz == `SGD_SIZE_4) widen = {{4{pr[1]}}, {4{pr[0]}}};
    else widen = s;
  endfunction

  assign sub_last  = (mode[`SGD_MODE_SIZE] == `SGD_SIZE_2) ? 2'h1 :
                     (mode[`SGD_MODE_SIZE] == `SGD_SIZE_4) ? 2'h3 : 2'h0;
  assign code_cap  = disp_win && phase == 2'h1;
  assign slice_cap = disp_win && phase == 2'h3;

  // internal bus drive; display windows and access cycles never overlap
  always_comb begin
    bus_addr           = 10'h000;
    page_mem_strobe_n  = 1'b1;
    glyph_gen_strobe_n = 1'b1;
    internal_rw        = 1'b1;
    bus_dout_oe_n      = 1'b1;
    if (disp_win) begin
      if (!phase[1]) begin
        bus_addr          = win_addr;
        page_mem_strobe_n = phase != 2'h1;
      end else begin
        bus_addr                = {5'h00, ctype[`SGD_TYPE_EXT], slice};
        glyph_gen_strobe_n      = phase != 2'h3;
      end
    end else if (acc_state == SGD_A_XFER) begin
      bus_addr           = xfer_addr;
      internal_rw        = !xf_write;
      bus_dout_oe_n      = !xf_write;
      page_mem_strobe_n  = !(phase == 2'h1 && !xf_glyph);
      glyph_gen_strobe_n = !(phase == 2'h1 && xf_glyph);
    end
  end

  // window code fetch
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      attr           <= 7'h00;
      ctype          <= 4'h0;
      char_code_regs <= 9'h000;
      fetch_addr     <= 10'h000;
    end else if (code_cap) begin
      attr           <= bus_din[`SGD_CODE_ATTR];
      ctype          <= bus_din[`SGD_CODE_TYPE];
      char_code_regs <= bus_din[`SGD_CODE_CHAR];
      fetch_addr     <= win_addr;
    end
  end

  // window addressing: each row is re-read for all ten tv lines
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      win_addr  <= 10'h000;
      row_base  <= 10'h000;
      roll_base <= 10'h000;
    end else if (frame_start) begin
      roll_base <= mode[`SGD_MODE_ROLL] ? roll_base + 10'(`SGD_VIS_WINDOWS) : roll_base;
      row_base  <= mode[`SGD_MODE_ROLL] ? roll_base + 10'(`SGD_VIS_WINDOWS) : roll_base;
      win_addr  <= mode[`SGD_MODE_ROLL] ? roll_base + 10'(`SGD_VIS_WINDOWS) : roll_base;
    end else if (line_end) begin
      if (slice == 4'(`SGD_WIN_TV_LINES - 1)) row_base <= win_addr;
      else win_addr <= row_base;
    end else if (code_cap && sub == sub_last) begin
      win_addr <= win_addr + 10'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || line_end) sub <= 2'h0;
    else if (slice_cap) sub <= (sub == sub_last) ? 2'h0 : sub + 2'h1;
  end

  // slice read and video shifter, two dots per clock
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shifter <= 8'h00;
      colour  <= 3'h0;
      box_q   <= 1'b0;
      vid_on  <= 1'b0;
    end else if (slice_cap) begin
      shifter <= widen(bus_din[`SGD_WIN_DOTS-1:0], mode[`SGD_MODE_SIZE], sub);
      colour  <= attr[`SGD_ATTR_RGB];
      box_q   <= attr[`SGD_ATTR_BOX] || fetch_addr == cursor;
      vid_on  <= mode[`SGD_MODE_ON];
    end else begin
      shifter <= {shifter[5:0], 2'b00};
      if (phase == 2'h3) vid_on <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      red    <= 2'b00;
      green  <= 2'b00;
      blue   <= 2'b00;
      boxing <= 1'b0;
    end else begin
      red    <= shifter[7:6] & {2{vid_on && colour[2]}};
      green  <= shifter[7:6] & {2{vid_on && colour[1]}};
      blue   <= shifter[7:6] & {2{vid_on && colour[0]}};
      boxing <= vid_on && box_q;
    end
  end

  // access automaton
  assign opcode   = mb.first[`SGD_OP];
  assign cmd_val  = {mb.first[`SGD_HI], mb.second};
  assign xf_write = xmode == SGD_XF_PM_WR || xmode == SGD_XF_CG_WR;
  assign xf_glyph = xmode == SGD_XF_CG_WR || xmode == SGD_XF_CG_RD;
  assign cmd_take = !disp_win && acc_state == SGD_A_IDLE && mb.cmd_pend;
  assign xf_done  = acc_state == SGD_A_XFER && phase == 2'h1;
  assign mb.take  = cmd_take || xf_done;
  assign mb.load  = xf_done && !xf_write;
  assign mb.load_first  = xf_glyph ? mb.first : bus_din[15:8];
  assign mb.load_second = bus_din[7:0];
  assign mb.rd_mode     = !xf_write;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode   <= `SGD_MODE_RESET;
      cursor <= 10'h000;
      xmode  <= SGD_XF_PM_WR;
    end else if (cmd_take) begin
      case (opcode)
        `SGD_OP_CURSOR: cursor <= cmd_val;
        `SGD_OP_MODE:   mode <= mb.second;
        `SGD_OP_XFER:   xmode <= sgd_xfer_e'(mb.first[`SGD_XMODE]);
        default:        mode <= mode;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc_state <= SGD_A_IDLE;
      xfer_addr <= 10'h000;
      bus_dout  <= 16'h0000;
    end else begin
      case (acc_state)
        SGD_A_IDLE: begin
          if (cmd_take && opcode == `SGD_OP_XFER) xfer_addr <= cmd_val;
          else if (!disp_win && !mb.cmd_pend && mb.data_pend && phase == 2'h0) begin
            acc_state <= SGD_A_XFER;
            bus_dout  <= {mb.first, mb.second};
          end
        end
        SGD_A_XFER: begin
          if (xf_done) begin
            acc_state <= SGD_A_IDLE;
            xfer_addr <= xfer_addr + 10'h001;
          end
        end
        default: acc_state <= SGD_A_IDLE;
      endcase
    end
  end

  AST_STROBE_EXCL: assert property (@(posedge ref_clk) disable iff (rst)
    !(!page_mem_strobe_n && !glyph_gen_strobe_n))
    else $error("both memory strobes active");
  AST_TWO_READS: assert property (@(posedge ref_clk) disable iff (rst)
    disp_win && phase == 2'h0 |-> ##1 !page_mem_strobe_n && internal_rw ##2 !glyph_gen_strobe_n && internal_rw)
    else $error("display window lacks two reads");
  AST_ACCESS_OWN: assert property (@(posedge ref_clk) disable iff (rst)
    !disp_win && (!page_mem_strobe_n || !glyph_gen_strobe_n) |-> acc_state == SGD_A_XFER && phase == 2'h1)
    else $error("strobe outside display with no access cycle");
  AST_CODE_LATCH: assert property (@(posedge ref_clk) disable iff (rst)
    code_cap |=> char_code_regs == $past(bus_din[8:0]) && attr == $past(bus_din[15:9]))
    else $error("window code not latched");
  AST_ADDR_INC: assert property (@(posedge ref_clk) disable iff (rst)
    code_cap && sub == sub_last && !line_end |=> win_addr == $past(win_addr) + 10'h001)
    else $error("window address not advanced");
  AST_SLICE_ADDR: assert property (@(posedge ref_clk) disable iff (rst)
    disp_win && !glyph_gen_strobe_n |-> bus_addr[3:0] == slice && slice <= 4'd9 && bus_addr[9:5] == 5'h00)
    else $error("slice address wrong");
  AST_RW_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
    !bus_dout_oe_n |-> !internal_rw && !disp_win)
    else $error("data driven without write");
  AST_VIDEO: assert property (@(posedge ref_clk) disable iff (rst)
    slice_cap && mode[0] && attr[2] && bus_din[7:6] == 2'b11 && mode[4:3] == 2'h0 |-> ##2 red == 2'b11)
    else $error("video not delivered after slice");
  AST_CMD_SERVICE: assert property (@(posedge ref_clk) disable iff (rst)
    mb.cmd_pend && !disp_win && acc_state == SGD_A_IDLE |-> mb.take)
    else $error("pending command not fetched");
  AST_XFER_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
    acc_state == SGD_A_XFER && xf_write |-> !bus_dout_oe_n && !internal_rw && bus_addr == xfer_addr)
    else $error("write transfer not driven");
  AST_XFER_LOAD: assert property (@(posedge ref_clk) disable iff (rst)
    xf_done && !xf_write && !xf_glyph |=> mb.first == 8'($past(bus_din) >> 8))
    else $error("read transfer not loaded into mailbox");
  AST_DISP_RW: assert property (@(posedge ref_clk) disable iff (rst)
    disp_win |-> internal_rw && bus_dout_oe_n)
    else $error("display window not a read");
  AST_ACCESS_WIN: assert property (@(posedge ref_clk) disable iff (rst)
    acc_state == SGD_A_XFER |-> !disp_win)
    else $error("access transfer inside display window");
  AST_MODE_SET: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_take && opcode == `SGD_OP_MODE |=> mode == $past(mb.second))
    else $error("mode command not applied");
  AST_CURSOR_SET: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_take && opcode == `SGD_OP_CURSOR |=> cursor == $past(cmd_val))
    else $error("cursor command not applied");
  AST_SIZE_GROUP: assert property (@(posedge ref_clk) disable iff (rst)
    slice_cap && sub == sub_last && !line_end |=> sub == 2'h0)
    else $error("character group not restarted");
  AST_TYPE_LATCH: assert property (@(posedge ref_clk) disable iff (rst)
    code_cap |=> ctype == 4'($past(bus_din) >> 12))
    else $error("character type not latched");
  AST_VIDEO_BLANK: assert property (@(posedge ref_clk) disable iff (rst)
    !vid_on |=> red == 2'b00 && green == 2'b00 && blue == 2'b00 && !boxing)
    else $error("video shown while blanked");
endmodule // sgd_bus_sequencer

// [sgd_bus_mem_model.sv]
`timescale 1ns/1ps
module sgd_bus_mem_model (
  input  wire logic        ref_clk,
  input  wire logic [9:0]  bus_addr,
  output logic [15:0]      bus_din,
  input  wire logic [15:0] bus_dout,
  input  wire logic        bus_dout_oe_n,
  input  wire logic        page_mem_strobe_n,
  input  wire logic        glyph_gen_strobe_n,
  input  wire logic        internal_rw
);
  logic [15:0] pm [1024];
  logic [7:0]  glyph [1024];
  logic [15:0] rd_word;
  logic [15:0] last = 16'h0000;
  logic        rd_sel;

  initial begin
    for (int i = 0; i < 1024; i++) begin
      pm[i] = 16'h0000;
      glyph[i] = 8'h00;
    end
  end

  // page memory answers its own strobe, glyph store its own
  always_comb begin
    rd_sel = internal_rw && !(page_mem_strobe_n && glyph_gen_strobe_n);
    rd_word = !page_mem_strobe_n ? pm[bus_addr] : {glyph[bus_addr], glyph[bus_addr]};
  end

  // released bus shows a stale inverted word, never a kind copy
  assign bus_din = rd_sel ? rd_word : ~last;

  always @(posedge ref_clk) begin
    if (rd_sel) begin
      last <= rd_word;
    end
    if (!page_mem_strobe_n && !internal_rw && !bus_dout_oe_n) begin
      pm[bus_addr] <= bus_dout;
    end
    if (!glyph_gen_strobe_n && !internal_rw && !bus_dout_oe_n) begin
      glyph[bus_addr] <= bus_dout[7:0];
    end
  end
endmodule // sgd_bus_mem_model

// [sgd_bus_sequencer_bench.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; $display("FAIL %s expected %h got %h", nm, (e), (g)); end end
module sgd_bus_sequencer_bench;
  import sgd_pkg::*;
  localparam int LW  = 44;
  localparam int FL  = 260;
  localparam int VIS = 250;
  localparam int LC  = 4 * LW;

  logic        ref_clk;
  logic        rst;
  logic [1:0]  host_addr;
  logic [7:0]  host_wdata;
  logic        host_wr;
  logic        host_rd;
  logic [7:0]  host_rdata;
  logic [9:0]  bus_addr;
  logic [15:0] bus_din;
  logic [15:0] bus_dout;
  logic        bus_dout_oe_n;
  logic        page_mem_strobe_n;
  logic        glyph_gen_strobe_n;
  logic        internal_rw;
  logic [8:0]  char_code_regs;
  sgd_dots_t   red;
  sgd_dots_t   green;
  sgd_dots_t   blue;
  logic        boxing;
  int          fail_count;
  int          cmp_count;
  int          c;
  int          vid;
  int          bx;
  int          ph;
  int          col;
  int          line;
  logic        run;
  logic [7:0]  rv;
  logic [7:0]  r0;

  sgd_bus_sequencer #(.LINE_WIN(LW), .FRAME_LINES(FL)) sgd_bus_sequencer_inst (
    .ref_clk            (ref_clk),
    .rst                (rst),
    .host_addr          (host_addr),
    .host_wdata         (host_wdata),
    .host_wr            (host_wr),
    .host_rd            (host_rd),
    .host_rdata         (host_rdata),
    .bus_addr           (bus_addr),
    .bus_din            (bus_din),
    .bus_dout           (bus_dout),
    .bus_dout_oe_n      (bus_dout_oe_n),
    .page_mem_strobe_n  (page_mem_strobe_n),
    .glyph_gen_strobe_n (glyph_gen_strobe_n),
    .internal_rw        (internal_rw),
    .char_code_regs     (char_code_regs),
    .red                (red),
    .green              (green),
    .blue               (blue),
    .boxing             (boxing)
  );

  sgd_bus_mem_model sgd_bus_mem_model_inst (
    .ref_clk            (ref_clk),
    .bus_addr           (bus_addr),
    .bus_din            (bus_din),
    .bus_dout           (bus_dout),
    .bus_dout_oe_n      (bus_dout_oe_n),
    .page_mem_strobe_n  (page_mem_strobe_n),
    .glyph_gen_strobe_n (glyph_gen_strobe_n),
    .internal_rw        (internal_rw)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic hwr(input logic [1:0] a, input logic [7:0] d);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge ref_clk);
    host_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic hrd(input logic [1:0] a, output logic [7:0] d);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge ref_clk);
    host_rd <= 1'b0;
    #1 d = host_rdata;
    @(posedge ref_clk);
  endtask

  // first then second register under command select
  task automatic cmd(input logic [7:0] f, input logic [7:0] s);
    hwr(2'b10, f);
    hwr(2'b11, s);
  endtask

  task automatic wait_idle;
    int n;
    logic [7:0] b;
    n = 0;
    b = 8'h80;
    while (b[7] === 1'b1 && n < 2000) begin
      hrd(2'b10, b);
      n++;
    end
    `CHK("busy_clear", 1'b0, b[7])
  endtask

  // per-cycle view of the display windows, cycle 0 is the first after reset
  always @(posedge ref_clk) begin
    #1;
    if (run) begin
      ph = c % 4;
      col = (c / 4) % LW;
      line = (c / LC) % FL;
      `CHK("strobe_overlap", 1'b1, page_mem_strobe_n | glyph_gen_strobe_n)
      if (col < 40 && line < VIS) begin
        `CHK("pm_strobe", ph != 1, page_mem_strobe_n)
        `CHK("cg_strobe", ph != 3, glyph_gen_strobe_n)
        `CHK("disp_bus_drive", 1'b1, bus_dout_oe_n)
        if (ph == 1 || ph == 3) `CHK("disp_rw", 1'b1, internal_rw)
        if (ph == 1 && line < 10) `CHK("win_addr", 10'(col), bus_addr)
        if (ph == 3) `CHK("slice_addr", 5'(line % 10), bus_addr[4:0])
      end
      if (c == 2) `CHK("char_code0", 9'h023, char_code_regs)
      if (c == 6) `CHK("char_code1", 9'h011, char_code_regs)
      if (c < LC && red == 2'b11 && green == 2'b11 && blue == 2'b11) begin
        vid++;
      end
      if (c < LC && boxing === 1'b1) bx++;
      if (c == LC) `CHK("video_dots", 4, vid)
      if (c == LC) `CHK("boxing_dots", 4, bx)
      c++;
    end
  end

  initial begin
    rst = 1'b1;
    host_addr = 2'b00;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
    run = 1'b0;
    c = 0;
    vid = 0;
    bx = 0;
    fail_count = 0;
    cmp_count = 0;
    repeat (20) @(posedge ref_clk);
    // window 0: white, boxed; window 1 black
    sgd_bus_mem_model_inst.pm[0] = 16'h1e23;
    sgd_bus_mem_model_inst.pm[1] = 16'h0011;
    sgd_bus_mem_model_inst.glyph[0] = 8'hff;
    `CHK("rst_pm_strobe", 1'b1, page_mem_strobe_n)
    `CHK("rst_oe", 1'b1, bus_dout_oe_n)
    `CHK("rst_rdata", 8'h00, host_rdata)
    rst <= 1'b0;
    run = 1'b1;
    repeat (LC + 4) @(posedge ref_clk);
    while (c % LC != 4) @(posedge ref_clk);
    cmd(8'h00, 8'h00);
    hrd(2'b10, rv);
    `CHK("busy_set", 1'b1, rv[7])
    wait_idle();
    cmd(8'h10, 8'h01);
    wait_idle();
    for (int m = 0; m < 4; m++) begin
      cmd(8'h21 | 8'(m << 2), 8'h40);
      wait_idle();
      if (m % 2 == 0) begin
        hwr(2'b00, (m == 0) ? 8'h5a : 8'h3c);
        hwr(2'b01, (m == 0) ? 8'ha5 : 8'hc3);
      end else begin
        hrd(2'b01, rv);
        wait_idle();
        hrd(2'b00, r0);
        hrd(2'b01, rv);
      end
      wait_idle();
      case (m)
        0: `CHK("pm_write", 16'h5aa5, sgd_bus_mem_model_inst.pm[10'h140])
        1: `CHK("pm_read", 16'h5aa5, {r0, rv})
        2: `CHK("cg_write", 8'hc3, sgd_bus_mem_model_inst.glyph[10'h140])
        default: `CHK("cg_read", 8'hc3, rv)
      endcase
    end
    report_and_stop();
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    report_and_stop();
  end
endmodule // sgd_bus_sequencer_bench
